/* File: gil_pkg.sv */
// Package for the gauge initialisation and lifetime log register bank.
// Assumes a 100 MHz core clock and a word-wide command port in front.
package gil_pkg;

  // ----------------------------------------------------------------
  // Register command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] GIL_TIME_UNTIL_EMPTY = 8'h03;
  localparam logic [7:0] GIL_SAMPLE_RESEED = 8'h04;
  localparam logic [7:0] GIL_TIME_UNTIL_FULL = 8'h05;
  localparam logic [7:0] GIL_PRESENT_RESEED = 8'h07;
  localparam logic [7:0] GIL_CELL_VOLTAGE = 8'h09;
  localparam logic [7:0] GIL_RELATIVE_CHARGE = 8'h0D;
  localparam logic [7:0] GIL_FINE_CHARGE = 8'h0F;
  localparam logic [7:0] GIL_POWER_MODE = 8'h15;
  localparam logic [7:0] GIL_CYCLE_COUNT = 8'h17;
  localparam logic [7:0] GIL_RUNTIME_LO = 8'h24;
  localparam logic [7:0] GIL_RUNTIME_HI = 8'h25;
  localparam logic [7:0] GIL_TEMP_ACC_LO = 8'h26;
  localparam logic [7:0] GIL_TEMP_ACC_HI = 8'h27;
  localparam logic [7:0] GIL_CHG_ACC_LO = 8'h28;
  localparam logic [7:0] GIL_CHG_ACC_HI = 8'h29;
  localparam logic [7:0] GIL_PEAK_VOLT = 8'h2A;
  localparam logic [7:0] GIL_LOW_VOLT = 8'h2B;
  localparam logic [7:0] GIL_PEAK_TEMP = 8'h2C;
  localparam logic [7:0] GIL_LOW_TEMP = 8'h2D;
  localparam logic [7:0] GIL_HEALTH = 8'h32;

  // ----------------------------------------------------------------
  // Command data, modes and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] GIL_SEED_KEY1 = 16'hAA55;
  localparam logic [15:0] GIL_SEED_KEY4 = 16'hAA58;
  localparam logic [15:0] GIL_MODE_OPER = 16'h0001;
  localparam logic [15:0] GIL_MODE_SLEEP = 16'h0002;
  localparam logic [15:0] GIL_HEALTH_RST = 16'h0064;
  localparam logic [15:0] GIL_FULL_PCT = 16'h0064;
  localparam logic [15:0] GIL_TEMP_DIV = 16'h0014;
  localparam logic [23:0] GIL_RUNTIME_MAX = 24'hFFFFFF;
  localparam logic [31:0] GIL_ACC_MAX = 32'hFFFFFFFF;
  localparam int GIL_NUM_SAMPLES = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint GIL_CLK_HZ = 100000000;
  localparam longint GIL_SAMPLE_MS = 10;
  localparam longint GIL_MINUTE_S = 60;
  localparam longint GIL_SAMPLE_CYCLES = GIL_SAMPLE_MS * GIL_CLK_HZ / 1000;
  localparam longint GIL_MINUTE_CYCLES = GIL_MINUTE_S * GIL_CLK_HZ;

  typedef enum logic [0:0] {GIL_SMP_IDLE, GIL_SMP_RUN} gil_smp_state_t;

endpackage

/* File: gil_registers.sv */
// Initialisation commands, reports and lifetime log registers of a gauge.
// Assumes a command-layer word port (code, 16-bit data, strobes) decoded from
// the serial bus, and the gauging core supplying estimates and measurements.
`timescale 1ns/100ps
`default_nettype none
module gil_registers import gil_pkg::*; #(
  parameter longint SAMPLE_CYCLES = GIL_SAMPLE_CYCLES,
  parameter longint MINUTE_CYCLES = GIL_MINUTE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  output logic [15:0] cmd_rdata,
  input wire logic battery_insert,
  input wire logic [15:0] cell_voltage_mv,
  input wire logic [15:0] cell_temperature,
  input wire logic [15:0] est_relative_charge,
  input wire logic [15:0] est_fine_charge,
  input wire logic [15:0] est_time_empty,
  input wire logic [15:0] est_time_full,
  input wire logic [15:0] est_health,
  output logic reseed_valid,
  output logic [15:0] open_circuit_voltage,
  output logic operational
);

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Strobe and code are passed in so the wires below follow every change of them
  function automatic logic hit(input logic wr, input logic [7:0] code, input logic [7:0] want);
    hit = wr && (code == want);
  endfunction

  wire logic wr_mode = hit(cmd_wr, cmd_code, GIL_POWER_MODE);
  wire logic wr_charge = hit(cmd_wr, cmd_code, GIL_RELATIVE_CHARGE);
  wire logic wr_rt_lo = hit(cmd_wr, cmd_code, GIL_RUNTIME_LO);
  wire logic wr_rt_hi = hit(cmd_wr, cmd_code, GIL_RUNTIME_HI);
  wire logic wr_ta_lo = hit(cmd_wr, cmd_code, GIL_TEMP_ACC_LO);
  wire logic wr_ta_hi = hit(cmd_wr, cmd_code, GIL_TEMP_ACC_HI);
  wire logic wr_ca_lo = hit(cmd_wr, cmd_code, GIL_CHG_ACC_LO);
  wire logic wr_ca_hi = hit(cmd_wr, cmd_code, GIL_CHG_ACC_HI);
  wire logic sample_cmd = hit(cmd_wr, cmd_code, GIL_SAMPLE_RESEED)
    && (cmd_wdata >= GIL_SEED_KEY1) && (cmd_wdata <= GIL_SEED_KEY4);
  wire logic present_cmd = hit(cmd_wr, cmd_code, GIL_PRESENT_RESEED)
    && (cmd_wdata == GIL_SEED_KEY1);
  wire logic [1:0] sample_sel = cmd_wdata[1:0] - GIL_SEED_KEY1[1:0];

  // ----------------------------------------------------------------
  // Power mode and minute base
  // ----------------------------------------------------------------
  logic [15:0] mode_reg;
  logic [32:0] minute_cnt_reg;
  logic minute_tick;

  // Other mode values are stored but only value one runs the block
  assign operational = (mode_reg == GIL_MODE_OPER);
  // Counter holds in sleep so a minute is not shortened by a nap
  assign minute_tick = operational && (minute_cnt_reg == 33'(MINUTE_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= GIL_MODE_OPER;
      minute_cnt_reg <= '0;
    end else begin
      if (wr_mode) mode_reg <= cmd_wdata;
      if (minute_tick) minute_cnt_reg <= '0;
      else if (operational) minute_cnt_reg <= minute_cnt_reg + 33'd1;
    end
  end

  // ----------------------------------------------------------------
  // Post-insertion sampling
  // ----------------------------------------------------------------
  gil_smp_state_t smp_state_reg;
  logic [19:0] smp_cnt_reg;
  logic [1:0] smp_idx_reg;
  logic [15:0] sample_mem [GIL_NUM_SAMPLES];
  wire logic smp_take = (smp_state_reg == GIL_SMP_RUN)
    && (smp_cnt_reg == 20'(SAMPLE_CYCLES - 1));

  // Samples are taken 10 ms, 20 ms, 30 ms and 40 ms after insertion
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      smp_state_reg <= GIL_SMP_IDLE;
      smp_cnt_reg <= '0;
      smp_idx_reg <= '0;
    end else begin
      case (smp_state_reg)
        GIL_SMP_IDLE: begin
          if (battery_insert) smp_state_reg <= GIL_SMP_RUN;
          smp_cnt_reg <= '0;
          smp_idx_reg <= '0;
        end
        GIL_SMP_RUN: begin
          smp_cnt_reg <= smp_take ? 20'd0 : smp_cnt_reg + 20'd1;
          if (smp_take) begin
            smp_idx_reg <= smp_idx_reg + 2'd1;
            if (smp_idx_reg == 2'(GIL_NUM_SAMPLES - 1)) smp_state_reg <= GIL_SMP_IDLE;
          end
        end
        default: smp_state_reg <= GIL_SMP_IDLE;
      endcase
    end
  end

  // Sample store, one slot per sampling instant
  genvar gi;
  generate
    for (gi = 0; gi < GIL_NUM_SAMPLES; gi++) begin : g_smp
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) sample_mem[gi] <= '0;
        else if (smp_take && smp_idx_reg == 2'(gi)) sample_mem[gi] <= cell_voltage_mv;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Reseed requests to the gauging core
  // ----------------------------------------------------------------
  wire logic auto_seed = smp_take && (smp_idx_reg == 2'd0);

  // Host commands win over the automatic seed landing in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reseed_valid <= 1'b0;
      open_circuit_voltage <= '0;
    end else begin
      reseed_valid <= sample_cmd || present_cmd || auto_seed;
      if (sample_cmd) open_circuit_voltage <= sample_mem[sample_sel];
      else if (present_cmd) open_circuit_voltage <= cell_voltage_mv;
      else if (auto_seed) open_circuit_voltage <= cell_voltage_mv;
    end
  end

  // ----------------------------------------------------------------
  // Reports
  // ----------------------------------------------------------------
  logic [15:0] charge_reg, fine_reg, tte_reg, ttf_reg, health_reg;
  logic forced_reg;
  wire logic charge_above = charge_reg > est_relative_charge;

  // A forced value walks one percent per minute back to the estimate
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      charge_reg <= '0;
      forced_reg <= 1'b0;
      fine_reg <= '0;
      tte_reg <= '0;
      ttf_reg <= '0;
      health_reg <= GIL_HEALTH_RST;
    end else if (wr_charge) begin
      charge_reg <= cmd_wdata;
      forced_reg <= 1'b1;
    end else if (operational) begin
      fine_reg <= est_fine_charge;
      tte_reg <= est_time_empty;
      ttf_reg <= est_time_full;
      health_reg <= est_health;
      if (!forced_reg || charge_reg == est_relative_charge) begin
        charge_reg <= est_relative_charge;
        forced_reg <= 1'b0;
      end else if (minute_tick) begin
        charge_reg <= charge_above ? charge_reg - 16'd1 : charge_reg + 16'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Cycle counter
  // ----------------------------------------------------------------
  logic [15:0] cycles_reg, drop_reg, prev_charge_reg;
  wire logic charge_fell = operational && (charge_reg < prev_charge_reg) && !wr_charge;
  wire logic [15:0] drop_sum = drop_reg + (charge_fell ? prev_charge_reg - charge_reg : 16'd0);

  // Host writes to the charge are not counted as a decrease
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cycles_reg <= '0;
      drop_reg <= '0;
      prev_charge_reg <= '0;
    end else begin
      prev_charge_reg <= wr_charge ? cmd_wdata : charge_reg;
      if (battery_insert) begin
        cycles_reg <= '0;
        drop_reg <= '0;
      end else if (drop_sum >= GIL_FULL_PCT) begin
        cycles_reg <= cycles_reg + 16'd1;
        drop_reg <= drop_sum - GIL_FULL_PCT;
      end else begin
        drop_reg <= drop_sum;
      end
    end
  end

  // ----------------------------------------------------------------
  // Runtime and accumulators
  // ----------------------------------------------------------------
  logic [23:0] runtime_reg;
  logic [31:0] temp_acc_reg, chg_acc_reg;
  wire logic [32:0] temp_sum = {1'b0, temp_acc_reg} + 33'(cell_temperature / GIL_TEMP_DIV);
  wire logic [32:0] chg_sum = {1'b0, chg_acc_reg} + 33'(charge_reg);

  // Sums clamp at all ones so a late carry cannot wrap to a small value
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      runtime_reg <= '0;
      temp_acc_reg <= '0;
      chg_acc_reg <= '0;
    end else begin
      if (battery_insert) runtime_reg <= '0;
      else if (wr_rt_lo) runtime_reg[15:0] <= cmd_wdata;
      else if (wr_rt_hi) runtime_reg[23:16] <= cmd_wdata[7:0];
      else if (minute_tick && runtime_reg != GIL_RUNTIME_MAX)
        runtime_reg <= runtime_reg + 24'd1;
      if (wr_ta_lo) temp_acc_reg[15:0] <= cmd_wdata;
      else if (wr_ta_hi) temp_acc_reg[31:16] <= cmd_wdata;
      else if (minute_tick)
        temp_acc_reg <= temp_sum[32] ? GIL_ACC_MAX : temp_sum[31:0];
      if (wr_ca_lo) chg_acc_reg[15:0] <= cmd_wdata;
      else if (wr_ca_hi) chg_acc_reg[31:16] <= cmd_wdata;
      else if (minute_tick)
        chg_acc_reg <= chg_sum[32] ? GIL_ACC_MAX : chg_sum[31:0];
    end
  end

  // ----------------------------------------------------------------
  // Min and max trackers
  // ----------------------------------------------------------------
  logic [15:0] vmax_reg, vmin_reg, tmax_reg, tmin_reg;

  // Low trackers reset high so the first reading always lands
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vmax_reg <= '0;
      vmin_reg <= 16'hFFFF;
      tmax_reg <= '0;
      tmin_reg <= 16'hFFFF;
    end else begin
      if (hit(cmd_wr, cmd_code, GIL_PEAK_VOLT)) vmax_reg <= cmd_wdata;
      else if (operational && cell_voltage_mv > vmax_reg) vmax_reg <= cell_voltage_mv;
      if (hit(cmd_wr, cmd_code, GIL_LOW_VOLT)) vmin_reg <= cmd_wdata;
      else if (operational && cell_voltage_mv < vmin_reg) vmin_reg <= cell_voltage_mv;
      if (hit(cmd_wr, cmd_code, GIL_PEAK_TEMP)) tmax_reg <= cmd_wdata;
      else if (operational && cell_temperature > tmax_reg) tmax_reg <= cell_temperature;
      if (hit(cmd_wr, cmd_code, GIL_LOW_TEMP)) tmin_reg <= cmd_wdata;
      else if (operational && cell_temperature < tmin_reg) tmin_reg <= cell_temperature;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [15:0] rd_mux;

  // Write-only command codes and unknown codes read as zero
  always_comb begin
    if (cmd_code == GIL_TIME_UNTIL_EMPTY) rd_mux = tte_reg;
    else if (cmd_code == GIL_TIME_UNTIL_FULL) rd_mux = ttf_reg;
    else if (cmd_code == GIL_CELL_VOLTAGE) rd_mux = cell_voltage_mv;
    else if (cmd_code == GIL_RELATIVE_CHARGE) rd_mux = charge_reg;
    else if (cmd_code == GIL_FINE_CHARGE) rd_mux = fine_reg;
    else if (cmd_code == GIL_POWER_MODE) rd_mux = mode_reg;
    else if (cmd_code == GIL_CYCLE_COUNT) rd_mux = cycles_reg;
    else if (cmd_code == GIL_RUNTIME_LO) rd_mux = runtime_reg[15:0];
    else if (cmd_code == GIL_RUNTIME_HI) rd_mux = {8'h00, runtime_reg[23:16]};
    else if (cmd_code == GIL_TEMP_ACC_LO) rd_mux = temp_acc_reg[15:0];
    else if (cmd_code == GIL_TEMP_ACC_HI) rd_mux = temp_acc_reg[31:16];
    else if (cmd_code == GIL_CHG_ACC_LO) rd_mux = chg_acc_reg[15:0];
    else if (cmd_code == GIL_CHG_ACC_HI) rd_mux = chg_acc_reg[31:16];
    else if (cmd_code == GIL_PEAK_VOLT) rd_mux = vmax_reg;
    else if (cmd_code == GIL_LOW_VOLT) rd_mux = vmin_reg;
    else if (cmd_code == GIL_PEAK_TEMP) rd_mux = tmax_reg;
    else if (cmd_code == GIL_LOW_TEMP) rd_mux = tmin_reg;
    else if (cmd_code == GIL_HEALTH) rd_mux = health_reg;
    else rd_mux = 16'h0000;
  end

  // Read data holds until the next read strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cmd_rdata <= '0;
    else if (cmd_rd) cmd_rdata <= rd_mux;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_SAMPLE_STORE: assert property (smp_take |=> sample_mem[$past(smp_idx_reg)] == $past(cell_voltage_mv))
    else $error("sample not stored");
  AST_AUTO_SEED: assert property (auto_seed && !sample_cmd && !present_cmd |=> reseed_valid && open_circuit_voltage == $past(cell_voltage_mv))
    else $error("automatic seed missing");
  AST_SAMPLE_CMD: assert property (sample_cmd |=> reseed_valid && open_circuit_voltage == $past(sample_mem[cmd_wdata[1:0] - 2'd1]))
    else $error("sample reseed wrong");
  AST_PRESENT_CMD: assert property (present_cmd && !sample_cmd |=> open_circuit_voltage == $past(cell_voltage_mv))
    else $error("present reseed wrong");
  AST_SLEEP_FREEZE: assert property (!operational && !cmd_wr |=> $stable(charge_reg) && $stable(runtime_reg) && $stable(chg_acc_reg))
    else $error("register moved in sleep");
  AST_HEALTH_FOLLOW: assert property (rst_b && operational && !cmd_wr |=> health_reg == $past(est_health))
    else $error("health not tracking");
  AST_RUNTIME_SAT: assert property (runtime_reg == GIL_RUNTIME_MAX && !cmd_wr && !battery_insert |=> runtime_reg == GIL_RUNTIME_MAX)
    else $error("runtime wrapped");
  AST_RUNTIME_STEP: assert property (minute_tick && !cmd_wr && !battery_insert && runtime_reg != GIL_RUNTIME_MAX |=> runtime_reg == $past(runtime_reg) + 24'd1)
    else $error("runtime did not count");
  AST_CHG_ACC: assert property (minute_tick && !cmd_wr && !chg_sum[32] |=> chg_acc_reg == $past(chg_acc_reg) + 32'($past(charge_reg)))
    else $error("charge accumulator wrong");
  AST_TEMP_ACC: assert property (minute_tick && !cmd_wr && !temp_sum[32] |=> temp_acc_reg == $past(temp_acc_reg) + 32'($past(cell_temperature) / 32'd20))
    else $error("temperature accumulator wrong");
  AST_VMAX: assert property (rst_b && operational && !cmd_wr |=> vmax_reg >= $past(cell_voltage_mv))
    else $error("peak voltage missed");
  AST_VMIN: assert property (rst_b && operational && !cmd_wr |=> vmin_reg <= $past(cell_voltage_mv))
    else $error("lowest voltage missed");
  AST_TICK_GATE: assert property (!operational |=> $stable(minute_cnt_reg))
    else $error("tick outside operation");

  COV_FOUR_SAMPLES: cover property (smp_take && smp_idx_reg == 2'd3);
  COV_SAMPLE_CMD: cover property (sample_cmd ##1 reseed_valid);
  COV_CYCLE: cover property (cycles_reg == 16'd1);
  COV_CONVERGE: cover property (forced_reg ##1 !forced_reg);

endmodule
`default_nettype wire

/* File: gil_host_model.sv */
// Host processor model: issues word writes and reads on the command port.
// Assumes one calling process and the design's one-cycle strobes.
`timescale 1ns/100ps
`default_nettype none
module gil_host_model (
  input wire logic clk,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  output logic cmd_wr,
  output logic cmd_rd,
  input wire logic [15:0] cmd_rdata
);
  // Idle port at time zero
  initial begin
    cmd_code = 8'hFF;
    cmd_wdata = 16'h0000;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
  end
  // ------------------------------------------------------------
  // Word accesses
  // ------------------------------------------------------------
  // Strobe rises after an edge and falls after the taking edge
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    cmd_code <= c;
    cmd_wdata <= d;
    cmd_wr <= 1'b1;
    @(posedge clk);
    cmd_wr <= 1'b0;
    cmd_wdata <= ~d; // Released data is scrambled so nothing leans on it
  endtask
  // Read data is loaded at the taking edge, so look just after it
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    @(posedge clk);
    cmd_code <= c;
    cmd_rd <= 1'b1;
    @(posedge clk);
    cmd_rd <= 1'b0;
    #1 d = cmd_rdata;
  endtask
endmodule
`default_nettype wire

/* File: gauge_init_and_log_registers_tb.sv */
// Self-checking bench for the gauge init and log register bank.
// Assumes short sample and minute counts set through the parameters.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module gauge_init_and_log_registers_tb;
  import gil_pkg::*;
  typedef struct {logic w; logic [7:0] c; logic [15:0] d; logic [15:0] e;} gil_row_t;
  logic clk, rst_b, battery_insert, cmd_wr, cmd_rd, reseed_valid, operational;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, open_circuit_voltage, rv, n, last_ocv;
  logic [15:0] cell_voltage_mv, cell_temperature, est_relative_charge;
  logic [15:0] est_fine_charge, est_time_empty, est_time_full, est_health;
  int fail_count = 0;
  int tests_run = 0;
  int seeds = 0;
  int cycles = 0;
  gil_row_t rows [11] = '{
    '{1'b0, GIL_FINE_CHARGE, 16'h0000, 16'h01F4},
    '{1'b0, GIL_TIME_UNTIL_EMPTY, 16'h0000, 16'h0078},
    '{1'b0, GIL_TIME_UNTIL_FULL, 16'h0000, 16'h003C},
    '{1'b0, GIL_HEALTH, 16'h0000, 16'h005F},
    '{1'b1, GIL_PEAK_VOLT, 16'h0100, 16'h0E20},
    '{1'b1, GIL_LOW_VOLT, 16'hFFF0, 16'h0E20},
    '{1'b1, GIL_PEAK_TEMP, 16'h0001, 16'h0BB8},
    '{1'b1, GIL_LOW_TEMP, 16'hFFFE, 16'h0BB8},
    '{1'b0, GIL_CELL_VOLTAGE, 16'h0000, 16'h0E20},
    '{1'b0, GIL_POWER_MODE, 16'h0000, 16'h0001},
    '{1'b1, 8'h44, 16'h1234, 16'h0000}};
  gil_registers #(.SAMPLE_CYCLES(8), .MINUTE_CYCLES(20)) u_gil_registers (
    .clk(clk), .rst_b(rst_b), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
    .battery_insert(battery_insert), .cell_voltage_mv(cell_voltage_mv),
    .cell_temperature(cell_temperature), .est_relative_charge(est_relative_charge),
    .est_fine_charge(est_fine_charge), .est_time_empty(est_time_empty),
    .est_time_full(est_time_full), .est_health(est_health),
    .reseed_valid(reseed_valid), .open_circuit_voltage(open_circuit_voltage),
    .operational(operational));
  gil_host_model u_gil_host_model (.clk(clk), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata));
  // ------------------------------------------------------------
  // Clock, seed monitor, timeout and verdict
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Seed voltage is loaded with the pulse and held until the next seed, so catch it there
  always @(posedge clk) begin
    if (reseed_valid === 1'b1) begin
      seeds <= seeds + 1;
      last_ocv <= open_circuit_voltage;
    end
  end
  // Whole run needs about 2500 cycles; a hang ends well past that
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rchk(input logic [7:0] c, input logic [15:0] e);
    u_gil_host_model.rd(c, rv);
    `CHK(rv, e)
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    u_gil_host_model.wr(c, d);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    battery_insert = 1'b0;
    cell_voltage_mv = 16'h0E00;
    cell_temperature = 16'h0BB8;
    est_relative_charge = 16'h0032;
    est_fine_charge = 16'h01F4;
    est_time_empty = 16'h0078;
    est_time_full = 16'h003C;
    est_health = 16'h005F;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    // Insertion: each sample window sees its own voltage
    @(posedge clk);
    battery_insert <= 1'b1;
    cell_voltage_mv <= 16'h0E01;
    @(posedge clk);
    battery_insert <= 1'b0;
    repeat (12) @(posedge clk);
    cell_voltage_mv <= 16'h0E02;
    repeat (8) @(posedge clk);
    cell_voltage_mv <= 16'h0E03;
    repeat (8) @(posedge clk);
    cell_voltage_mv <= 16'h0E04;
    repeat (12) @(posedge clk);
    `CHK(seeds, 1)
    `CHK(last_ocv, 16'h0E01)
    for (int k = 0; k < 4; k++) begin
      wr(GIL_SAMPLE_RESEED, GIL_SEED_KEY1 + 16'(k));
      repeat (2) @(posedge clk);
      `CHK(last_ocv, 16'h0E01 + 16'(k))
    end
    cell_voltage_mv <= 16'h0E20;
    wr(GIL_PRESENT_RESEED, GIL_SEED_KEY1);
    repeat (2) @(posedge clk);
    `CHK(last_ocv, 16'h0E20)
    wr(GIL_SAMPLE_RESEED, GIL_SEED_KEY4 + 16'h0001);
    wr(GIL_PRESENT_RESEED, GIL_SEED_KEY1 + 16'h0001);
    repeat (2) @(posedge clk);
    `CHK(seeds, 6)
    // Ordinary reads and tracker restarts
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].c, rows[i].d);
      rchk(rows[i].c, rows[i].e);
    end
    // Counters frozen in sleep, then a window of two to three minutes in operation
    wr(GIL_POWER_MODE, GIL_MODE_SLEEP);
    @(posedge clk);
    `CHK(operational, 1'b0)
    wr(GIL_RELATIVE_CHARGE, 16'h0032);
    wr(GIL_RUNTIME_LO, 16'h1234);
    wr(GIL_RUNTIME_HI, 16'h0000);
    wr(GIL_TEMP_ACC_LO, 16'h0010);
    wr(GIL_TEMP_ACC_HI, 16'h0000);
    wr(GIL_CHG_ACC_LO, 16'h0020);
    wr(GIL_CHG_ACC_HI, 16'h0000);
    repeat (50) @(posedge clk);
    rchk(GIL_RUNTIME_LO, 16'h1234);
    rchk(GIL_CHG_ACC_LO, 16'h0020);
    wr(GIL_POWER_MODE, GIL_MODE_OPER);
    repeat (50) @(posedge clk);
    wr(GIL_POWER_MODE, GIL_MODE_SLEEP);
    u_gil_host_model.rd(GIL_RUNTIME_LO, rv);
    n = rv - 16'h1234;
    `CHK(n >= 16'h0002 && n <= 16'h0003, 1'b1)
    rchk(GIL_TEMP_ACC_LO, 16'h0010 + n * 16'h0096);
    rchk(GIL_CHG_ACC_LO, 16'h0020 + n * 16'h0032);
    // Saturation at the top and a forced charge that drifts back
    wr(GIL_RUNTIME_LO, 16'hFFFF);
    wr(GIL_RUNTIME_HI, 16'h00FF);
    wr(GIL_CHG_ACC_LO, 16'hFFFF);
    wr(GIL_CHG_ACC_HI, 16'hFFFF);
    wr(GIL_RELATIVE_CHARGE, 16'h0050);
    wr(GIL_POWER_MODE, GIL_MODE_OPER);
    repeat (45) @(posedge clk);
    wr(GIL_POWER_MODE, GIL_MODE_SLEEP);
    rchk(GIL_RUNTIME_LO, 16'hFFFF);
    rchk(GIL_RUNTIME_HI, 16'h00FF);
    rchk(GIL_CHG_ACC_HI, 16'hFFFF);
    u_gil_host_model.rd(GIL_RELATIVE_CHARGE, rv);
    `CHK(rv < 16'h0050 && rv > 16'h004C, 1'b1)
    // A full discharge of one hundred percent makes one cycle
    wr(GIL_RELATIVE_CHARGE, 16'h0064);
    est_relative_charge <= 16'h0000;
    wr(GIL_POWER_MODE, GIL_MODE_OPER);
    repeat (2200) @(posedge clk);
    wr(GIL_POWER_MODE, GIL_MODE_SLEEP);
    rchk(GIL_CYCLE_COUNT, 16'h0001);
    rchk(GIL_RELATIVE_CHARGE, 16'h0000);
    // Mid-run reset from sleep: logs clear and the block wakes operational
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    `CHK(operational, 1'b1)
    rchk(GIL_CHG_ACC_HI, 16'h0000);
    rchk(GIL_CYCLE_COUNT, 16'h0000);
    rchk(GIL_RUNTIME_HI, 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
